/* mdac_pkg.sv */
/*
 * constants and carrier types shared by the multichannel dac register datapath.
 * assumes a single 100 MHz clock domain and a word-aligned AHB-Lite register map.
 */
`default_nettype none

package mdac_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NCH = 40;
    localparam int NGRP = 5;
    localparam int GRP_SIZE = 8;
    localparam int DW = 16;
    localparam int CW = 6;

    // ------------------------------------------------------------
    // register byte offsets (low address byte)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ALL_SRC = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_GAIN = 8'h10;
    localparam logic [7:0] OFS_OFFSET = 8'h14;
    localparam logic [7:0] OFS_RB_SEL = 8'h18;
    localparam logic [7:0] OFS_RB_DATA = 8'h1C;
    localparam logic [7:0] OFS_SRC_BASE = 8'h20;
    localparam logic [7:0] OFS_SRC_LAST = 8'h30;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_SET_BIT = 0;
    localparam int CHAN_LSB = 16;
    localparam int RB_SET_BIT = 8;
    localparam int STAT_CLEAR_BIT = 8;

    // ------------------------------------------------------------
    // values after reset, clear code and mid-scale offset
    // ------------------------------------------------------------
    localparam logic [DW-1:0] GAIN_RST = 16'hFFFF;
    localparam logic [DW-1:0] OFFSET_RST = 16'h8000;
    localparam logic [DW-1:0] DATA_RST = 16'h0000;
    localparam logic [DW-1:0] CLEAR_CODE = 16'h0000;
    localparam logic [18:0] OFFSET_MID = 19'h08000;

    // ------------------------------------------------------------
    // carriers between the register file and the calibration stage
    // ------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [CW-1:0] chan;
        logic set;
        logic [DW-1:0] data;
        logic [DW-1:0] gain;
        logic [DW-1:0] offset;
    } mdac_cal_req_t;

    typedef struct packed {
        logic valid;
        logic [CW-1:0] chan;
        logic set;
        logic [DW-1:0] value;
    } mdac_cal_rsp_t;

endpackage

`default_nettype wire

/* mdac_cal.sv */
/*
 * one-stage calibration pipe: value = data*(gain+1)/65536 + offset - 32768, clamped.
 * assumes the request is stable for the one cycle in which valid is high.
 */
`timescale 1ns/1ps
`default_nettype none

module mdac_cal
    import mdac_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire mdac_pkg::mdac_cal_req_t req,
    output mdac_pkg::mdac_cal_rsp_t rsp
);

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    logic [33:0] prod;
    logic [16:0] scaled;
    logic signed [18:0] sum;
    mdac_cal_rsp_t next_rsp;

    // gain of all ones is unity; offset at mid-scale adds nothing
    always_comb begin
        prod = {17'h00000, req.data} * ({17'h00000, req.gain} + 34'h000000001);
        scaled = prod[32:16];
        sum = $signed({2'b00, scaled}) + $signed({3'b000, req.offset}) - $signed(OFFSET_MID);
        next_rsp.valid = req.valid;
        next_rsp.chan = req.chan;
        next_rsp.set = req.set;
        // saturate rather than wrap so a bad trim cannot fold an output across the range
        if (sum < 0) begin
            next_rsp.value = 16'h0000;
        end else if (sum > $signed(19'h0FFFF)) begin
            next_rsp.value = 16'hFFFF;
        end else begin
            next_rsp.value = sum[15:0];
        end
    end

    // result register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

endmodule

`default_nettype wire

/* mdac_core.sv */
/*
 * register datapath of a 40-channel dac: input, calibrated and dac registers,
 * input-set and source selection, group deglitch, load strobe and clear pin.
 * assumes an AHB-Lite master on the same clock; strobe and clear pins are asynchronous.
 */
// Operation
// (RQ1) calibrate every input register write with trims
// (RQ2) shared select steers write and calibrated result
// (RQ3) one control bit selects input set globally
// (RQ4) per-channel selector picks dac register source
// (RQ5) single write switches all source selectors
// (RQ6) forty channels in five groups of eight
// (RQ7) eight-bit source register per group
// (RQ8) data write arms group deglitch
// (RQ9) deglitch acts on whole changing group
// (RQ10) selector changes never arm deglitch
// (RQ11) host writes each group after selector change; the bench loads straight after without these writes
// (RQ12) load strobe updates outputs, fires deglitch
// (RQ13) clear pin forces outputs to clear code
// (RQ14) calibrated value held until own input rewritten
`timescale 1ns/1ps
`default_nettype none

module mdac_core
    import mdac_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic load_dac_strobe,
    input wire logic clear_pin,
    output logic [mdac_pkg::NCH-1:0][mdac_pkg::DW-1:0] dac_out,
    output logic [mdac_pkg::NGRP-1:0] deglitch
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic chan_ok(input logic [CW-1:0] c);
        chan_ok = (c < CW'(NCH));
    endfunction

    function automatic logic src_hit(input logic [7:0] a);
        src_hit = (a >= OFS_SRC_BASE) && (a <= OFS_SRC_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [2:0] src_grp(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_SRC_BASE;
        src_grp = d[4:2];
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic ap_wr, next_ap_wr;
    logic [7:0] ap_addr, next_ap_addr;
    logic [31:0] next_hrdata;
    logic input_sel, next_input_sel;
    logic [NCH-1:0] src_bits, next_src_bits;
    logic [CW-1:0] rb_chan, next_rb_chan;
    logic rb_set, next_rb_set;
    logic [NCH-1:0][DW-1:0] in_a, next_in_a, in_b, next_in_b;
    logic [NCH-1:0][DW-1:0] gain, next_gain, offs, next_offs;
    logic [NCH-1:0][DW-1:0] cal_a, next_cal_a, cal_b, next_cal_b;
    logic [NCH-1:0][DW-1:0] dac_reg, next_dac_reg, next_dac_out;
    logic [NGRP-1:0] pend, next_pend, next_deglitch;
    logic [2:0] ld_sync;
    logic [1:0] clr_sync;
    logic load_pulse, clear_lvl;
    logic [CW-1:0] wr_chan;
    logic wr_data, wr_ctrl, wr_all, wr_gain, wr_offs, wr_rb, wr_src;
    logic [2:0] wr_grp;
    mdac_cal_req_t cal_req;
    mdac_cal_rsp_t cal_rsp;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // stage 0 feeds only stage 1; the edge detect looks at stages 1 and 2
    always_ff @(posedge clock) begin
        if (!nrst) begin
            ld_sync <= 3'h0;
            clr_sync <= 2'h0;
        end else begin
            ld_sync <= {ld_sync[1:0], load_dac_strobe};
            clr_sync <= {clr_sync[0], clear_pin};
        end
    end

    assign load_pulse = ld_sync[1] & ~ld_sync[2];
    assign clear_lvl = clr_sync[1];

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    // zero wait states, always OKAY; unmapped reads give zero and writes are dropped
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // address phase capture and read data prepared for the data phase
    always_comb begin
        next_ap_wr = hsel && htrans[1] && hready && hwrite;
        next_ap_addr = haddr[7:0];
        next_hrdata = 32'h00000000;
        if (hsel && htrans[1] && hready && !hwrite) begin
            if (haddr[7:0] == OFS_CTRL) begin
                next_hrdata[CTRL_SET_BIT] = input_sel;
            end else if (haddr[7:0] == OFS_STATUS) begin
                next_hrdata[NGRP-1:0] = pend;
                next_hrdata[STAT_CLEAR_BIT] = clear_lvl;
            end else if (haddr[7:0] == OFS_RB_SEL) begin
                next_hrdata[CHAN_LSB +: CW] = rb_chan;
                next_hrdata[RB_SET_BIT] = rb_set;
            end else if (haddr[7:0] == OFS_RB_DATA && chan_ok(rb_chan)) begin
                next_hrdata[15:0] = rb_set ? cal_b[rb_chan] : cal_a[rb_chan];
                next_hrdata[31:16] = dac_reg[rb_chan];
            end else if (src_hit(haddr[7:0])) begin
                next_hrdata[GRP_SIZE-1:0] = src_bits[src_grp(haddr[7:0])*GRP_SIZE +: GRP_SIZE]; // [RQ7]
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ap_wr <= 1'b0;
            ap_addr <= 8'h00;
            hrdata <= 32'h00000000;
        end else begin
            ap_wr <= next_ap_wr;
            ap_addr <= next_ap_addr;
            hrdata <= next_hrdata;
        end
    end

    // data-phase write strobes
    assign wr_chan = hwdata[CHAN_LSB +: CW];
    assign wr_data = ap_wr && (ap_addr == OFS_DATA) && chan_ok(wr_chan);
    assign wr_ctrl = ap_wr && (ap_addr == OFS_CTRL);
    assign wr_all = ap_wr && (ap_addr == OFS_ALL_SRC);
    assign wr_gain = ap_wr && (ap_addr == OFS_GAIN) && chan_ok(wr_chan);
    assign wr_offs = ap_wr && (ap_addr == OFS_OFFSET) && chan_ok(wr_chan);
    assign wr_rb = ap_wr && (ap_addr == OFS_RB_SEL);
    assign wr_src = ap_wr && src_hit(ap_addr);
    assign wr_grp = src_grp(ap_addr);

    // ------------------------------------------------------------
    // configuration and input registers
    // ------------------------------------------------------------
    always_comb begin
        next_input_sel = input_sel;
        next_src_bits = src_bits;
        next_rb_chan = rb_chan;
        next_rb_set = rb_set;
        next_in_a = in_a;
        next_in_b = in_b;
        next_gain = gain;
        next_offs = offs;
        if (wr_ctrl) begin
            next_input_sel = hwdata[CTRL_SET_BIT]; // [RQ3]
        end
        if (wr_all) begin
            next_src_bits = {NCH{hwdata[0]}}; // [RQ5]
        end else if (wr_src) begin
            next_src_bits[wr_grp*GRP_SIZE +: GRP_SIZE] = hwdata[GRP_SIZE-1:0]; // [RQ6] [RQ7]
        end
        if (wr_rb) begin
            next_rb_chan = hwdata[CHAN_LSB +: CW];
            next_rb_set = hwdata[RB_SET_BIT];
        end
        // the shared selector decides which input register takes the word
        if (wr_data && !input_sel) begin
            next_in_a[wr_chan] = hwdata[DW-1:0]; // [RQ2]
        end
        if (wr_data && input_sel) begin
            next_in_b[wr_chan] = hwdata[DW-1:0]; // [RQ2]
        end
        if (wr_gain) begin
            next_gain[wr_chan] = hwdata[DW-1:0];
        end
        if (wr_offs) begin
            next_offs[wr_chan] = hwdata[DW-1:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            input_sel <= 1'b0;
            src_bits <= '0;
            rb_chan <= '0;
            rb_set <= 1'b0;
            in_a <= {NCH{DATA_RST}};
            in_b <= {NCH{DATA_RST}};
            gain <= {NCH{GAIN_RST}};
            offs <= {NCH{OFFSET_RST}};
        end else begin
            input_sel <= next_input_sel;
            src_bits <= next_src_bits;
            rb_chan <= next_rb_chan;
            rb_set <= next_rb_set;
            in_a <= next_in_a;
            in_b <= next_in_b;
            gain <= next_gain;
            offs <= next_offs;
        end
    end

    // ------------------------------------------------------------
    // calibration
    // ------------------------------------------------------------
    // trims are read in the write cycle, so a trim change only affects later writes
    always_comb begin
        cal_req.valid = wr_data; // [RQ1]
        cal_req.chan = wr_chan;
        cal_req.set = input_sel; // [RQ3]
        cal_req.data = hwdata[DW-1:0];
        cal_req.gain = gain[wr_chan];
        cal_req.offset = offs[wr_chan];
    end

    mdac_cal u_cal (
        .clock(clock),
        .nrst(nrst),
        .req(cal_req),
        .rsp(cal_rsp)
    );

    // only the result of its own set touches a calibrated register
    always_comb begin
        next_cal_a = cal_a;
        next_cal_b = cal_b;
        if (cal_rsp.valid && !cal_rsp.set) begin
            next_cal_a[cal_rsp.chan] = cal_rsp.value; // [RQ2] [RQ14]
        end
        if (cal_rsp.valid && cal_rsp.set) begin
            next_cal_b[cal_rsp.chan] = cal_rsp.value; // [RQ2] [RQ14]
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cal_a <= {NCH{DATA_RST}};
            cal_b <= {NCH{DATA_RST}};
        end else begin
            cal_a <= next_cal_a;
            cal_b <= next_cal_b;
        end
    end

    // ------------------------------------------------------------
    // dac registers, deglitch and outputs
    // ------------------------------------------------------------
    // a write landing with the load stays armed for the next load: set wins
    always_comb begin
        next_pend = load_pulse ? '0 : pend; // [RQ12]
        if (cal_req.valid) begin
            next_pend[cal_req.chan[5:3]] = 1'b1; // [RQ8] [RQ10]
        end
        next_deglitch = load_pulse ? pend : '0; // [RQ9] [RQ12]
        next_dac_reg = dac_reg;
        for (int i = 0; i < NCH; i++) begin
            if (load_pulse) begin
                next_dac_reg[i] = src_bits[i] ? cal_b[i] : cal_a[i]; // [RQ4] [RQ12]
            end
            // clear overrides the outputs but leaves the dac registers intact
            next_dac_out[i] = clear_lvl ? CLEAR_CODE : next_dac_reg[i]; // [RQ13]
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pend <= '0;
            deglitch <= '0;
            dac_reg <= {NCH{DATA_RST}};
            dac_out <= {NCH{CLEAR_CODE}};
        end else begin
            pend <= next_pend;
            deglitch <= next_deglitch;
            dac_reg <= next_dac_reg;
            dac_out <= next_dac_out;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // selector changes leave deglitch state alone; the bench loads straight after them with no dummy write
    a_cal_timing: assert property (@(posedge clock) disable iff (!nrst) // [RQ1]
        wr_data |-> ##1 (cal_rsp.valid && cal_rsp.chan == $past(wr_chan)))
        else $error("calibration result missing after data write");
    a_input_steer: assert property (@(posedge clock) disable iff (!nrst) // [RQ2]
        (cal_rsp.valid && !cal_rsp.set) |=> cal_a[$past(cal_rsp.chan)] == $past(cal_rsp.value))
        else $error("first calibrated register not written");
    a_shared_select: assert property (@(posedge clock) disable iff (!nrst) // [RQ3]
        wr_data |=> (cal_rsp.set == $past(input_sel)) && (input_sel ? in_b[$past(wr_chan)]
            : in_a[$past(wr_chan)]) == $past(hwdata[DW-1:0]))
        else $error("input set not taken from control bit");
    a_load_source: assert property (@(posedge clock) disable iff (!nrst) // [RQ4]
        load_pulse |=> dac_reg[NCH-1] == ($past(src_bits[NCH-1]) ? $past(cal_b[NCH-1]) : $past(cal_a[NCH-1])))
        else $error("dac register loaded from wrong source");
    a_all_switch: assert property (@(posedge clock) disable iff (!nrst) // [RQ5]
        wr_all |=> src_bits == {NCH{$past(hwdata[0])}})
        else $error("global source switch incomplete");
    a_group_select: assert property (@(posedge clock) disable iff (!nrst) // [RQ7]
        (wr_src && !wr_all && wr_grp == 3'h4) |=> src_bits[39:32] == $past(hwdata[7:0]))
        else $error("group source register not written");
    a_deglitch_arm: assert property (@(posedge clock) disable iff (!nrst) // [RQ8]
        (wr_data && wr_chan == 6'h27) |=> pend[4])
        else $error("data write did not arm group deglitch");
    a_deglitch_fire: assert property (@(posedge clock) disable iff (!nrst) // [RQ9]
        load_pulse |=> (deglitch == $past(pend)) ##1 (deglitch == 5'h00))
        else $error("deglitch pulse wrong on load");
    a_src_quiet: assert property (@(posedge clock) disable iff (!nrst) // [RQ10]
        ((wr_src || wr_all) && !cal_req.valid && !load_pulse) |=> pend == $past(pend))
        else $error("selector change armed deglitch");
    a_clear_force: assert property (@(posedge clock) disable iff (!nrst) // [RQ13]
        clear_lvl |=> dac_out == {NCH{CLEAR_CODE}})
        else $error("clear did not force outputs");
    a_cal_hold: assert property (@(posedge clock) disable iff (!nrst) // [RQ14]
        !cal_rsp.valid |=> $stable(cal_a) && $stable(cal_b))
        else $error("calibrated register changed without its write");

    c_data_write: cover property (@(posedge clock) disable iff (!nrst) wr_data ##2 load_pulse);
    c_load_deglitch: cover property (@(posedge clock) disable iff (!nrst) load_pulse && pend != 5'h00);
    c_all_switch: cover property (@(posedge clock) disable iff (!nrst) wr_all ##[1:50] load_pulse);
    c_clear: cover property (@(posedge clock) disable iff (!nrst) clear_lvl ##1 !clear_lvl);

endmodule

`default_nettype wire

/* mdac_host.sv */
/*
 * host controller model: AHB-Lite single-word master and load strobe driver.
 * assumes one slave whose hreadyout is fed back as hready, same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module mdac_host (
    input wire logic clock,
    output var logic hsel,
    output var logic [31:0] haddr,
    output var logic [1:0] htrans,
    output var logic hwrite,
    output var logic [2:0] hsize,
    output var logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hready,
    output var logic load_dac_strobe
);
    // ------------------------------------------------------------
    // idle levels at time zero
    // ------------------------------------------------------------
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        load_dac_strobe = 1'b0;
    end

    // one single transfer; released lines show inverted garbage, not stale data
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r, output bit ok);
        int n;
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        n = 0;
        do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 50);
        ok = (hready === 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hwdata <= w ? d : ~hwdata;
        n = 0;
        do begin @(posedge clock); n++; end while (hready !== 1'b1 && n < 50);
        ok = ok && (hready === 1'b1);
        r = hrdata;
        hwdata <= ~d;
    endtask

    // strobe held three cycles so the pin synchroniser cannot miss it
    task automatic pulse_load();
        @(posedge clock);
        load_dac_strobe <= 1'b1;
        repeat (3) @(posedge clock);
        load_dac_strobe <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
/*
 * self-checking bench for the dac register datapath with an integer model.
 * assumes the host model in mdac_host and the register map of mdac_pkg.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import mdac_pkg::*;
    logic clock, nrst, clear_pin, load_dac_strobe;
    logic hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [NCH-1:0][DW-1:0] dac_out;
    logic [NGRP-1:0] deglitch;
    int num_errors = 0, checks = 0, seed;
    int cal_a[NCH], cal_b[NCH], gain_m[NCH], offs_m[NCH], dac_m[NCH];
    bit src_m[NCH];
    bit ok, inset;
    logic [4:0] armed;

    mdac_host host(.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata), .hready(hreadyout),
        .load_dac_strobe(load_dac_strobe));
    mdac_core dut(.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .load_dac_strobe(load_dac_strobe), .clear_pin(clear_pin), .dac_out(dac_out),
        .deglitch(deglitch));

    // ------------------------------------------------------------
    // checking and bus helpers
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // every channel against the model, or against the clear code
    task automatic cmp_dac(input bit clr);
        for (int i = 0; i < NCH; i++) cmp({16'h0, dac_out[i]}, clr ? 32'(CLEAR_CODE) : 32'(dac_m[i]));
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        host.xfer({24'h0, a}, w, d, rdv, ok);
        if (!ok) begin
            num_errors++;
            conclude();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        cmp(rdv, e);
    endtask

    // the bench's own calibration: identity at reset trims, clamped to 16 bits
    function automatic int calib(int d, int g, int o);
        longint v;
        v = ((longint'(d) * (g + 1)) >>> 16) + o - 32768;
        return (v < 0) ? 0 : (v > 65535) ? 65535 : int'(v);
    endfunction

    task automatic wr_data(input int ch, input int code);
        bus(OFS_DATA, 1'b1, (ch << CHAN_LSB) | (code & 16'hFFFF));
        if (inset) cal_b[ch] = calib(code & 16'hFFFF, gain_m[ch], offs_m[ch]);
        else cal_a[ch] = calib(code & 16'hFFFF, gain_m[ch], offs_m[ch]);
        armed[ch / GRP_SIZE] = 1'b1;
    endtask

    // strobe, collect deglitch pulses, then compare every output
    task automatic load();
        logic [4:0] dg;
        host.pulse_load();
        dg = 5'h0;
        repeat (10) begin @(posedge clock); dg |= deglitch; end
        cmp({27'h0, dg}, {27'h0, armed});
        for (int i = 0; i < NCH; i++) dac_m[i] = src_m[i] ? cal_b[i] : cal_a[i];
        armed = 5'h0;
        cmp_dac(1'b0);
    endtask

    // ------------------------------------------------------------
    // clock and main sequence
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        logic [7:0] b;
        int g, o;
        nrst = 1'b0;
        clear_pin = 1'b0;
        armed = 5'h0;
        inset = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            cal_a[i] = 0; cal_b[i] = 0; dac_m[i] = 0; src_m[i] = 0;
            gain_m[i] = int'(GAIN_RST);
            offs_m[i] = int'(OFFSET_RST);
        end
        seed = $urandom(98954);
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        cmp_dac(1'b0);
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_SRC_BASE + 8'h08, 32'h0);
        rd_chk(8'h40, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        $display("test reset done");

        // first set filled for all forty channels, then trims on one channel
        for (int c = 0; c < NCH; c++) wr_data(c, $urandom);
        g = $urandom & 16'hFFFF;
        o = $urandom & 16'hFFFF;
        bus(OFS_GAIN, 1'b1, (5 << CHAN_LSB) | g);
        bus(OFS_OFFSET, 1'b1, (5 << CHAN_LSB) | o);
        gain_m[5] = g;
        offs_m[5] = o;
        wr_data(5, $urandom);
        rd_chk(OFS_STATUS, {27'h0, armed});
        load();
        $display("test calibrate done");

        // preload one random code in the second set; outputs must not move
        bus(OFS_CTRL, 1'b1, 32'h1);
        inset = 1'b1;
        rd_chk(OFS_CTRL, 32'h1);
        o = $urandom & 16'hFFFF;
        for (int c = 0; c < NCH; c++) wr_data(c, o);
        load();
        bus(OFS_CTRL, 1'b1, 32'h0);
        inset = 1'b0;
        wr_data(10, $urandom);
        load();
        $display("test preload done");

        // one write swaps every channel to the second set and back
        bus(OFS_ALL_SRC, 1'b1, 32'h1);
        for (int i = 0; i < NCH; i++) src_m[i] = 1'b1;
        load();
        for (int k = 0; k < NGRP; k++) wr_data(k * GRP_SIZE + k, $urandom);
        load();
        bus(OFS_ALL_SRC, 1'b1, 32'h0);
        for (int i = 0; i < NCH; i++) src_m[i] = 1'b0;
        load();
        $display("test swap done");

        // independent source bits in each group register
        for (int k = 0; k < NGRP; k++) begin
            b = 8'($urandom);
            bus(OFS_SRC_BASE + 8'(4 * k), 1'b1, {24'h0, b});
            for (int j = 0; j < GRP_SIZE; j++) src_m[k * GRP_SIZE + j] = b[j];
            rd_chk(OFS_SRC_BASE + 8'(4 * k), {24'h0, b});
        end
        load();
        // read back one channel's second calibrated register and its dac register
        o = $urandom % NCH;
        bus(OFS_RB_SEL, 1'b1, (o << CHAN_LSB) | 32'h100);
        rd_chk(OFS_RB_SEL, (o << CHAN_LSB) | 32'h100);
        rd_chk(OFS_RB_DATA, (dac_m[o] << 16) | cal_b[o]);
        $display("test group select done");

        // clear pin overrides the outputs only while held
        @(posedge clock);
        clear_pin <= 1'b1;
        repeat (6) @(posedge clock);
        cmp_dac(1'b1);
        rd_chk(OFS_STATUS, 32'h100);
        clear_pin <= 1'b0;
        repeat (6) @(posedge clock);
        cmp_dac(1'b0);
        $display("test clear done");
        conclude();
    end
endmodule
`default_nettype wire
